// *** rtl/flash_rom_front.v ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_rom_defs.vh"
// Operation
// (R1) 16-bit data path, two-state byte/word access
// (R2) Even byte upper lane, odd byte lower
// (R3) Master issues word accesses at even addresses
// (R4) Mode pins select mode and ROM enable
// (R5) Both pins low: port-9 pins select mode
// (R6) Mode pins latched during reset
// (R7) Program writes 32-byte group at once
// (R8) Erase one block at a time
// (R9) Blocks of 1, 28, 16, 12, 2 kbytes
// (R10) Boot receiver auto-matches host bit rate
// (R11) Hardware, software, error protection states; here FC2_ERR is never set, so the error protection state is never entered
// (R12) First serial channel pins carry boot transfer; here boot_serial_tx_o is held at 1 in every mode
// (R13) ROM disabled: flash registers read zero
// (R14) Without write enable, ctrl two forced zero
// (R15) Select bit steers shared flash register addresses
// (R16) Expanded bit fixed per mode
// (R17) Expanded bit writable only in boot mode
// (R18) Mode register fixed bits read constant
// (R19) Mode status bits copy pins on read
// (R20) User mode refuses program and erase
// (R21) Boot mode erases whole array to 0xff
// (R22) Program bit needs enable and setup bits
// (R23) Read-only mode bits ignore writes
module flash_rom_front #(
  parameter ROM_AW = 15,                 // Word address bits of the array
  parameter OP_CYCLES = (`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire mclk_i,                     // System clock, 40 MHz
  input wire rst_i,                      // Asynchronous reset, active high
  input wire mode_pin_high_i,            // Mode pin, high bit
  input wire mode_pin_low_i,             // Mode pin, low bit
  input wire port9_mode_sel_2_i,         // Alternate mode select
  input wire port9_mode_sel_1_i,         // Alternate mode select
  input wire port9_mode_sel_0_i,         // Alternate mode select
  input wire hw_protect_i,               // Hardware protect request
  input wire boot_serial_rx_i,           // Boot serial receive
  output reg boot_serial_tx_o,           // Boot serial transmit
  input wire rom_req_i,                  // CPU ROM access request
  input wire [ROM_AW:0] rom_addr_i,      // CPU byte address
  input wire rom_word_i,                 // 1 word, 0 byte
  output reg rom_ack_o,                  // Access done, second state
  output reg [15:0] rom_rdata_o,         // Read data, even byte upper
  output wire rom_enable_o,              // ROM mapped in this mode
  output wire expanded_o,                // Expanded operation selected
  output wire boot_mode_o,               // Boot mode active
  output reg [15:0] arr_waddr_o,         // Array operation word address
  output reg [255:0] arr_wdata_o,        // Program group data
  output reg [1:0] arr_cmd_o,            // Array command pulse
  input wire [15:0] arr_rdata_i,         // Array read data
  input wire s_axi_awvalid,              // AXI4-Lite write address valid
  output wire s_axi_awready,             // Write address ready
  input wire [31:0] s_axi_awaddr,        // Write address
  input wire s_axi_wvalid,               // Write data valid
  output wire s_axi_wready,              // Write data ready
  input wire [31:0] s_axi_wdata,         // Write data
  input wire [3:0] s_axi_wstrb,          // Write strobes
  output reg s_axi_bvalid,               // Write response valid
  input wire s_axi_bready,               // Write response ready
  output reg [1:0] s_axi_bresp,          // Write response
  input wire s_axi_arvalid,              // Read address valid
  output wire s_axi_arready,             // Read address ready
  input wire [31:0] s_axi_araddr,        // Read address
  output reg s_axi_rvalid,               // Read data valid
  input wire s_axi_rready,               // Read data ready
  output reg [31:0] s_axi_rdata,         // Read data
  output reg [1:0] s_axi_rresp           // Read response
);
  // ********************************************************
  // Mode capture
  // ********************************************************
  localparam [2:0] BOOT_SEL = 3'h0;      // Port-9 code that means boot
  reg [1:0] pins_q;
  reg [2:0] p9_q;
  reg captured_q;
  wire pins_zero = ~pins_q[1] & ~pins_q[0];
  // Straps caught while reset holds via the first clocked edge after release
  always @(posedge mclk_i) begin
    if (!captured_q) begin
      pins_q <= {mode_pin_high_i, mode_pin_low_i}; // R6
      p9_q <= {port9_mode_sel_2_i, port9_mode_sel_1_i, port9_mode_sel_0_i}; // R5
    end
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      captured_q <= 1'b0;
    end else begin
      captured_q <= 1'b1;
    end
  end
  // Pins 1/0 mode 2, 1/1 mode 3 enable ROM; 0/1 is mode 1
  wire mode1 = ~pins_q[1] & pins_q[0];
  assign boot_mode_o = captured_q & pins_zero & (p9_q == BOOT_SEL);
  assign rom_enable_o = captured_q & ~mode1; // R4
  reg expanded_mode_enable_q;
  assign expanded_o = mode1 | expanded_mode_enable_q; // R16
  // ********************************************************
  // Registers
  // ********************************************************
  reg [7:0] fc1_q, fc2_q, ebr_q, wsc_q;
  reg [15:0] op_addr_q;
  reg [31:0] op_data_q;
  reg [2:0] op_lane_q;
  reg group_full_q;
  reg [15:0] baud_q;
  wire software_write_enable = fc1_q[`FC1_SOFTWARE_WRITE_ENABLE];
  wire flash_sel = wsc_q[`WSC_FLASH_SEL];
  wire user_mode = ~boot_mode_o;
  wire sw_prot = ~software_write_enable;
  wire prot = hw_protect_i | sw_prot | fc2_q[`FC2_ERR]; // R11
  // Mode bits may be set only once their setup bit stands
  wire erase_setup_ok = software_write_enable & fc2_q[`FC2_ESU];
  wire prog_setup_ok = software_write_enable & fc2_q[`FC2_PROGRAM_SETUP];
  // AXI write: take address and data in either order
  reg aw_q, w_q;
  reg [15:0] awi_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_q & w_q;
  wire wlane = ws_q[0];
  wire [7:0] wb = wd_q[7:0];
  wire fl_ok = rom_enable_o & flash_sel; // R13 R15
  wire wr_fc1 = wr_go & wlane & fl_ok & (awi_q == `IDX_FLASH_CTRL_ONE);
  wire wr_fc2 = wr_go & wlane & fl_ok & (awi_q == `IDX_FLASH_CTRL_TWO);
  wire wr_ebr = wr_go & wlane & fl_ok & (awi_q == `IDX_ERASE_BLOCK_TWO);
  wire wr_opc = wr_go & wlane & (awi_q == `IDX_OP_CTRL);
  // Operation engine state
  localparam [1:0] S_IDLE = 2'h0, S_BUSY = 2'h1;
  reg [1:0] st_q;
  reg [15:0] cnt_q;
  reg [1:0] cmd_q;
  reg refused_q;
  wire start_prog = fc1_q[`FC1_P] & (st_q == S_IDLE) & group_full_q;
  wire start_erase = fc1_q[`FC1_E] & (st_q == S_IDLE);
  // Erase block register one-hot: one block per operation
  wire ebr_onehot = (ebr_q != 8'h00) & ((ebr_q & (ebr_q - 8'h01)) == 8'h00); // R8
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fc1_q <= `RST_FLASH_CTRL_ONE;
      fc2_q <= `RST_FLASH_CTRL_TWO;
      ebr_q <= `RST_ERASE_BLOCK_TWO;
      wsc_q <= `RST_WAIT_CLOCK_CTRL;
      expanded_mode_enable_q <= 1'b0;
      op_addr_q <= 16'h0000;
      op_data_q <= 32'h0;
      op_lane_q <= 3'h0;
      group_full_q <= 1'b0;
      arr_wdata_o <= 256'h0;
      arr_waddr_o <= 16'h0000;
      arr_cmd_o <= `CMD_NONE;
      st_q <= S_IDLE;
      cnt_q <= 16'h0000;
      cmd_q <= `CMD_NONE;
      refused_q <= 1'b0;
    end else begin
      arr_cmd_o <= `CMD_NONE;
      if (wr_go && wlane && awi_q == `IDX_WAIT_CLOCK_CTRL) begin
        wsc_q <= wb;
      end
      // Expanded bit writes reach it only in boot mode, other bits are fixed
      if (wr_go && wlane && awi_q == `IDX_MODE_CTRL && boot_mode_o) begin
        expanded_mode_enable_q <= wb[`MDC_EXPANDED_MODE_ENABLE]; // R17 R23
      end
      if (wr_fc1) begin
        fc1_q[`FC1_SOFTWARE_WRITE_ENABLE] <= wb[`FC1_SOFTWARE_WRITE_ENABLE];
        fc1_q[`FC1_EV] <= wb[`FC1_EV] & software_write_enable;
        fc1_q[`FC1_PV] <= wb[`FC1_PV] & software_write_enable;
        fc1_q[`FC1_E] <= wb[`FC1_E] & erase_setup_ok & ~user_mode; // R20
        fc1_q[`FC1_P] <= wb[`FC1_P] & prog_setup_ok & ~user_mode; // R22 R20
      end
      if (wr_fc2) begin
        fc2_q[`FC2_ESU] <= wb[`FC2_ESU];
        fc2_q[`FC2_PROGRAM_SETUP] <= wb[`FC2_PROGRAM_SETUP];
      end
      if (wr_ebr) begin
        ebr_q <= wb;
      end
      // Program group fill: word written by index, eight words make 32 bytes
      if (wr_opc) begin
        if (ws_q[3]) begin
          op_lane_q <= 3'h0;
          group_full_q <= 1'b0;
          op_addr_q <= wd_q[31:16];
        end else if (!group_full_q) begin
          // The lane index wraps after eight words, so fullness is its own flag
          arr_wdata_o[op_lane_q*32 +: 32] <= wd_q; // R7
          op_lane_q <= op_lane_q + 3'h1;
          group_full_q <= (op_lane_q == 3'h7);
        end
      end
      if (wr_go && wlane && awi_q == `IDX_BOOT_SERIAL) begin
        op_data_q <= wd_q;
      end
      // Without write enable or under hardware protect, the low control bits and the erase block register clear
      if (!software_write_enable || hw_protect_i) begin
        fc2_q[1:0] <= 2'h0; // R14 R11
        ebr_q <= 8'h00; // R14
        fc1_q[3:0] <= 4'h0;
      end
      case (st_q)
        S_IDLE: begin
          if ((start_prog || start_erase) && (prot || user_mode)) begin
            refused_q <= 1'b1; // R20 R11
            fc2_q[`FC2_ERR] <= ~user_mode & ~hw_protect_i & ~sw_prot;
          end else if (start_prog) begin
            cmd_q <= `CMD_PROGRAM;
            arr_waddr_o <= op_addr_q;
            st_q <= S_BUSY;
            cnt_q <= 16'h0000;
          end else if (start_erase && boot_mode_o) begin
            cmd_q <= `CMD_TOTAL_ERASE; // R21
            arr_waddr_o <= 16'h0000;
            st_q <= S_BUSY;
            cnt_q <= 16'h0000;
          end else if (start_erase && ebr_onehot) begin
            cmd_q <= `CMD_BLOCK_ERASE; // R8 R9
            arr_waddr_o <= {8'h00, ebr_q};
            st_q <= S_BUSY;
            cnt_q <= 16'h0000;
          end
        end
        S_BUSY: begin
          if (cnt_q == OP_CYCLES[15:0] - 16'h0001) begin
            arr_cmd_o <= cmd_q;
            st_q <= S_IDLE;
            fc1_q[1:0] <= 2'h0;
            op_lane_q <= 3'h0;
            group_full_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
  // ********************************************************
  // AXI4-Lite handshakes
  // ********************************************************
  reg [7:0] rd_byte;
  reg rd_hit;
  wire [15:0] ari = s_axi_araddr[17:2];
  always @* begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ari)
      `IDX_FLASH_CTRL_ONE: rd_byte = fl_ok ? fc1_q : 8'h00; // R13
      `IDX_FLASH_CTRL_TWO: rd_byte = fl_ok ? fc2_q : 8'h00; // R13
      `IDX_ERASE_BLOCK_TWO: rd_byte = fl_ok ? ebr_q : 8'h00; // R13
      `IDX_WAIT_CLOCK_CTRL: rd_byte = wsc_q;
      // Status copies pins live at the read, fixed bits constant
      `IDX_MODE_CTRL: rd_byte = `MODE_CTRL_FIXED | {expanded_o, 5'h00,
        mode_pin_high_i, mode_pin_low_i}; // R18 R19 R16
      `IDX_OP_CTRL: rd_byte = {2'h0, st_q, refused_q, op_lane_q};
      `IDX_OP_STATUS: rd_byte = {boot_mode_o, expanded_o, rom_enable_o, prot, 4'h0};
      default: rd_hit = 1'b0;
    endcase
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awi_q <= 16'h0000;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awi_q <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awi_q >= `IDX_FLASH_CTRL_ONE) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ********************************************************
  // CPU ROM port and boot serial
  // ********************************************************
  reg state2_q;
  reg [15:0] bit_cnt_q;
  reg rx_d_q;
  // Two-state access: first state issues, second returns the lanes
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state2_q <= 1'b0;
      rom_ack_o <= 1'b0;
      rom_rdata_o <= 16'h0000;
      boot_serial_tx_o <= 1'b1;
      baud_q <= 16'h0000;
      bit_cnt_q <= 16'h0000;
      rx_d_q <= 1'b1;
    end else begin
      rom_ack_o <= 1'b0;
      state2_q <= rom_req_i & rom_enable_o & ~state2_q;
      if (state2_q) begin
        rom_ack_o <= 1'b1; // R1
        // Byte reads: even passes the whole word (byte in upper lane), odd copies the lower lane to both
        if (rom_word_i || !rom_addr_i[0]) begin
          rom_rdata_o <= arr_rdata_i; // R2 R3
        end else begin
          rom_rdata_o <= {arr_rdata_i[7:0], arr_rdata_i[7:0]}; // R2
        end
      end
      // Start bit width measures host rate (low time of first pulse)
      rx_d_q <= boot_serial_rx_i;
      if (boot_mode_o && baud_q == 16'h0000) begin
        if (!boot_serial_rx_i) begin
          bit_cnt_q <= bit_cnt_q + 16'h0001;
        end else if (!rx_d_q && bit_cnt_q >= `BAUD_MIN_BITS) begin
          baud_q <= bit_cnt_q; // R10
        end
      end
      boot_serial_tx_o <= boot_mode_o ? (op_data_q[0] | ~baud_q[0] | 1'b1) : 1'b1; // R12
    end
  end
endmodule
`default_nettype wire

// *** shared/flash_rom_defs.vh ***
`ifndef FLASH_ROM_DEFS_VH
`define FLASH_ROM_DEFS_VH
// ********************************************************
// Register indices on the AXI4-Lite slave
// ********************************************************
// Some indices are odd, so the bus byte address is four times the index
`define IDX_FLASH_CTRL_ONE 16'hff80
`define IDX_FLASH_CTRL_TWO 16'hff81
`define IDX_ERASE_BLOCK_TWO 16'hff83
`define IDX_WAIT_CLOCK_CTRL 16'hffc2
`define IDX_MODE_CTRL 16'hffc5
`define IDX_OP_CTRL 16'hffd0
`define IDX_OP_STATUS 16'hffd1
`define IDX_BOOT_SERIAL 16'hffd2
// ********************************************************
// Reset values and field positions
// ********************************************************
`define RST_FLASH_CTRL_ONE 8'h80
`define RST_FLASH_CTRL_TWO 8'h00
`define RST_ERASE_BLOCK_TWO 8'h00
`define RST_WAIT_CLOCK_CTRL 8'h08
`define MODE_CTRL_FIXED 8'h64
`define FC1_SOFTWARE_WRITE_ENABLE 6
`define FC1_EV 3
`define FC1_PV 2
`define FC1_E 1
`define FC1_P 0
`define FC2_ERR 7
`define FC2_ESU 1
`define FC2_PROGRAM_SETUP 0
`define WSC_FLASH_SEL 3
`define MDC_EXPANDED_MODE_ENABLE 7
// ********************************************************
// Operation commands and timing
// ********************************************************
`define CMD_NONE 2'h0
`define CMD_PROGRAM 2'h1
`define CMD_BLOCK_ERASE 2'h2
`define CMD_TOTAL_ERASE 2'h3
`define PROG_GROUP_BYTES 6'h20
`define OP_TIME_NS 1000
`define CLK_PERIOD_NS 25
`define BAUD_MIN_BITS 16'h0004
`endif

// *** sim/flash_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  input wire logic mclk_i, // System clock
  input wire logic [15:0] rom_addr_i, // CPU byte address
  input wire logic [1:0] arr_cmd_i, // Array command pulse
  output logic [15:0] arr_rdata_o // Word at that address
);
  logic erased_q = 1'b0;
  // A total erase leaves every cell at ff, even across a reset
  always @(posedge mclk_i) begin
    if (arr_cmd_i == 2'h3) begin
      erased_q <= 1'b1;
    end
  end
  // Pattern differs per word so a lane swap is visible
  assign arr_rdata_o = erased_q ? 16'hffff : {rom_addr_i[8:1] ^ 8'ha5, rom_addr_i[8:1]};
endmodule
`default_nettype wire

// *** sim/flash_rom_front_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_rom_front_sva #(
  parameter ROM_AW = 15
) (
  input wire mclk_i,
  input wire rst_i,
  input wire mode_pin_high_i,
  input wire mode_pin_low_i,
  input wire port9_mode_sel_2_i,
  input wire port9_mode_sel_1_i,
  input wire port9_mode_sel_0_i,
  input wire rom_req_i,
  input wire [ROM_AW:0] rom_addr_i,
  input wire rom_word_i,
  input wire rom_ack_o,
  input wire [15:0] rom_rdata_o,
  input wire rom_enable_o,
  input wire boot_mode_o,
  input wire boot_serial_tx_o,
  input wire [1:0] arr_cmd_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ROM answers in its second state with a one-cycle strobe
  chk_ack_two_state: assert property (
    $rose(rom_req_i) && rom_enable_o |-> ##[2:3] rom_ack_o) else $error("ROM ack late");
  chk_ack_one_cycle: assert property (
    rom_ack_o |=> !rom_ack_o) else $error("ROM ack too long");
  chk_odd_lane: assert property (
    rom_ack_o && rom_addr_i[0] && !rom_word_i |-> rom_rdata_o[15:8] == rom_rdata_o[7:0])
    else $error("odd byte lanes differ");
  chk_rom_off_quiet: assert property (
    !rom_enable_o |-> !rom_ack_o) else $error("ack with ROM off");
  // Straps count only at the first edge after reset
  chk_rom_by_pins: assert property (
    $fell(rst_i) |=> rom_enable_o == !(!mode_pin_high_i && mode_pin_low_i))
    else $error("ROM enable wrong");
  chk_boot_by_port9: assert property (
    $fell(rst_i) |=> boot_mode_o == !(mode_pin_high_i || mode_pin_low_i ||
      port9_mode_sel_2_i || port9_mode_sel_1_i || port9_mode_sel_0_i))
    else $error("boot mode wrong");
  chk_cmd_single: assert property (
    arr_cmd_o != 2'h0 |=> arr_cmd_o == 2'h0) else $error("array command held");
  chk_total_in_boot: assert property (
    arr_cmd_o == 2'h3 |-> boot_mode_o) else $error("total erase outside boot");
  chk_cmd_rom_on: assert property (
    arr_cmd_o != 2'h0 |-> rom_enable_o) else $error("array command with ROM off");
  chk_tx_idle: assert property (
    !boot_mode_o |-> boot_serial_tx_o) else $error("serial tx busy outside boot");
  cover property (rom_ack_o && rom_word_i);
  cover property (arr_cmd_o == 2'h3);
  cover property (arr_cmd_o == 2'h1);
endmodule
bind flash_rom_front flash_rom_front_sva #(.ROM_AW(ROM_AW)) flash_rom_front_sva_inst (
  .mclk_i, .rst_i, .mode_pin_high_i, .mode_pin_low_i, .port9_mode_sel_2_i,
  .port9_mode_sel_1_i, .port9_mode_sel_0_i, .rom_req_i, .rom_addr_i, .rom_word_i,
  .rom_ack_o, .rom_rdata_o, .rom_enable_o, .boot_mode_o, .boot_serial_tx_o, .arr_cmd_o);
`default_nettype wire

// *** sim/flash_rom_mode_and_access_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_rom_defs.vh"
module flash_rom_mode_and_access_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic mode_pin_high_i = 1'b1;
  logic mode_pin_low_i = 1'b1;
  logic port9_mode_sel_2_i = 1'b1;
  logic port9_mode_sel_1_i = 1'b1;
  logic port9_mode_sel_0_i = 1'b1;
  logic rom_req_i = 1'b0;
  logic rom_word_i = 1'b0;
  logic [15:0] rom_addr_i = 16'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire rom_ack_o, rom_enable_o, expanded_o, boot_mode_o;
  wire [1:0] s_axi_bresp, s_axi_rresp, arr_cmd_o;
  wire [31:0] s_axi_rdata;
  wire [15:0] rom_rdata_o, arr_rdata_i, arr_waddr_o;
  logic [15:0] last_addr = 16'h0;
  wire [255:0] arr_wdata_o;
  logic [31:0] rd_q, xg, xe, v;
  logic [1:0] rsp;
  logic [1:0] last_cmd = 2'h0;
  logic erased = 1'b0;
  integer num_errors = 0;
  integer checked = 0;
  integer i;
  // Protect and serial receive stay idle; boot rate logic is left alone
  flash_rom_front #(.OP_CYCLES(8)) flash_rom_front_inst (
    .mclk_i, .rst_i, .mode_pin_high_i, .mode_pin_low_i, .port9_mode_sel_2_i,
    .port9_mode_sel_1_i, .port9_mode_sel_0_i, .hw_protect_i(1'b0),
    .boot_serial_rx_i(1'b1), .boot_serial_tx_o(), .rom_req_i, .rom_addr_i, .rom_word_i,
    .rom_ack_o, .rom_rdata_o, .rom_enable_o, .expanded_o, .boot_mode_o, .arr_waddr_o,
    .arr_wdata_o, .arr_cmd_o, .arr_rdata_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  flash_array_model flash_array_model_inst (
    .mclk_i, .rom_addr_i, .arr_cmd_i(arr_cmd_o), .arr_rdata_o(arr_rdata_i));
  // ****
  // Helpers
  // ****
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  // The command pulse may land while a bus write is still finishing
  always @(posedge mclk_i) begin
    if (arr_cmd_o !== 2'h0) begin
      last_cmd <= arr_cmd_o;
      last_addr <= arr_waddr_o;
    end
  end
  task summarize;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task stuck;
    num_errors++;
    $display("[ERR] %0t ns: wait ran out", $time);
    summarize;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic [31:0] ra(input [15:0] idx);
    ra = {14'h0, idx, 2'h0};
  endfunction
  function automatic [15:0] d(input [15:0] a);
    d = erased ? 16'hffff : {a[8:1] ^ 8'ha5, a[8:1]};
  endfunction
  task do_reset(input [1:0] md, input [2:0] p9);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    {mode_pin_high_i, mode_pin_low_i} <= md;
    {port9_mode_sel_2_i, port9_mode_sel_1_i, port9_mode_sel_0_i} <= p9;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  // One AXI4-Lite transfer; each channel drops at its own handshake edge
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] dat, input logic [3:0] s);
    integer n;
    logic aw, w, ar, b;
    b = 1'b0;
    @(posedge mclk_i);
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= s;
    for (n = 0; n < 100 && !b; n++) begin
      @(negedge mclk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      b = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      rd_q = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
    end
    if (!b) stuck;
  endtask
  task wr(input [15:0] idx, input [7:0] val);
    bus(1'b1, ra(idx), {24'h0, val}, 4'h1);
  endtask
  task rd(input [15:0] idx, input [7:0] exp);
    bus(1'b0, ra(idx), 32'h0, 4'h0);
    check(rd_q[7:0], exp);
  endtask
  // Request held for the two states, then the ack strobe is awaited
  task rom(input [15:0] a, input w, input [15:0] exp, input [15:0] msk, input en);
    integer n;
    n = 0;
    @(posedge mclk_i);
    rom_req_i <= 1'b1;
    rom_addr_i <= a;
    rom_word_i <= w;
    repeat (2) @(posedge mclk_i);
    rom_req_i <= 1'b0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (rom_ack_o !== 1'b1 && n < 4);
    if (en && rom_ack_o !== 1'b1) stuck;
    check(rom_ack_o, en);
    if (en) check(rom_rdata_o & msk, exp & msk);
  endtask
  task wait_cmd(input [1:0] exp);
    integer n;
    for (n = 0; n < 200 && last_cmd === 2'h0; n++) @(posedge mclk_i);
    if (n == 200) stuck;
    check(last_cmd, exp);
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    do_reset(2'h3, 3'h7);
    rd(`IDX_WAIT_CLOCK_CTRL, 8'h08);
    rd(`IDX_FLASH_CTRL_ONE, 8'h80);
    rd(`IDX_MODE_CTRL, 8'h67);
    wr(`IDX_MODE_CTRL, 8'h98);
    rd(`IDX_MODE_CTRL, 8'h67);
    wr(`IDX_FLASH_CTRL_TWO, 8'h03);
    rd(`IDX_FLASH_CTRL_TWO, 8'h00);
    wr(`IDX_FLASH_CTRL_ONE, 8'h41);
    rd(`IDX_FLASH_CTRL_ONE, 8'hc0);
    wr(`IDX_FLASH_CTRL_TWO, 8'h01);
    wr(`IDX_ERASE_BLOCK_TWO, 8'h04);
    wr(`IDX_FLASH_CTRL_ONE, 8'h41);
    rd(`IDX_FLASH_CTRL_ONE, 8'hc0);
    wr(`IDX_FLASH_CTRL_ONE, 8'h00);
    rd(`IDX_FLASH_CTRL_TWO, 8'h00);
    rd(`IDX_ERASE_BLOCK_TWO, 8'h00);
    wr(`IDX_WAIT_CLOCK_CTRL, 8'h00);
    rd(`IDX_FLASH_CTRL_ONE, 8'h00);
    bus(1'b0, 32'h10, 32'h0, 4'h0);
    check(rsp, 2'h2);
    $display("register test done");
  endtask
  task t_rom;
    v = {16'h0, d(16'h0011)};
    rom(16'h0010, 1'b0, d(16'h0010), 16'hff00, 1'b1);
    rom(16'h0011, 1'b0, {v[7:0], v[7:0]}, 16'hffff, 1'b1);
    rom(16'h0246, 1'b1, d(16'h0246), 16'hffff, 1'b1);
    $display("ROM lane test done");
  endtask
  task t_modes;
    do_reset(2'h1, 3'h7);
    check(expanded_o, 1'b1);
    rom(16'h0010, 1'b0, 16'h0, 16'h0, 1'b0);
    rd(`IDX_MODE_CTRL, 8'he5);
    wr(`IDX_FLASH_CTRL_ONE, 8'h40);
    rd(`IDX_FLASH_CTRL_ONE, 8'h00);
    rd(`IDX_FLASH_CTRL_TWO, 8'h00);
    do_reset(2'h2, 3'h7);
    rd(`IDX_MODE_CTRL, 8'h66);
    rom(16'h0020, 1'b1, d(16'h0020), 16'hffff, 1'b1);
    $display("mode test done");
  endtask
  task t_boot;
    do_reset(2'h0, 3'h0);
    check(boot_mode_o, 1'b1);
    wr(`IDX_MODE_CTRL, 8'h80);
    rd(`IDX_MODE_CTRL, 8'he4);
    @(posedge mclk_i);
    mode_pin_low_i <= 1'b1;
    rd(`IDX_MODE_CTRL, 8'he5);
    check(boot_mode_o, 1'b1);
    wr(`IDX_FLASH_CTRL_ONE, 8'h40);
    wr(`IDX_FLASH_CTRL_TWO, 8'h02);
    last_cmd = 2'h0;
    wr(`IDX_FLASH_CTRL_ONE, 8'h42);
    wait_cmd(2'h3);
    check(last_addr, 32'h0);
    erased = 1'b1;
    rom(16'h0246, 1'b1, 16'hffff, 16'hffff, 1'b1);
    wr(`IDX_FLASH_CTRL_ONE, 8'h40);
    wr(`IDX_FLASH_CTRL_TWO, 8'h01);
    bus(1'b1, ra(`IDX_OP_CTRL), 32'h00400000, 4'hf);
    xe = 32'h0;
    for (i = 0; i < 8; i++) begin
      v = 32'h13579bd0 + i;
      xe = xe ^ v;
      bus(1'b1, ra(`IDX_OP_CTRL), v, 4'h7);
    end
    last_cmd = 2'h0;
    wr(`IDX_FLASH_CTRL_ONE, 8'h41);
    wait_cmd(2'h1);
    check(last_addr, 32'h40);
    xg = 32'h0;
    for (i = 0; i < 8; i++) xg = xg ^ arr_wdata_o[32*i +: 32];
    check(xg, xe);
    $display("boot test done");
  endtask
  initial begin
    t_regs;
    t_rom;
    t_modes;
    t_boot;
    summarize;
  end
  // Backstop against a hang outside the bounded waits
  initial begin
    repeat (20000) @(posedge mclk_i);
    stuck;
  end
endmodule
`default_nettype wire
